// ---- dv/boost_limit_host.sv ----
// host model issuing single-byte register requests
`timescale 1ns/1ps
module boost_limit_host (
  // clock
  input wire logic clk_i,
  // requests toward the register bank
  output boost_limit_pkg::reg_req_s req_o
);
  initial req_o = '0;
  // one strobe cycle a byte, moved just after the edge so the bank never sees a race
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 req_o = {wr, ~wr, a, d};
    @(posedge clk_i);
    #1 req_o = '0;
  endtask
endmodule

// ---- dv/test_boost_limit_config_regs.sv ----
// self-checking bench for the boost limit configuration registers
`timescale 1ns/1ps
module test_boost_limit_config_regs;
  logic clk_i = 0;
  logic resetn_i = 0;
  logic boost_i = 0;
  logic avg_i = 0;
  logic [7:0] rdata_o;
  boost_limit_pkg::reg_req_s req;
  boost_limit_pkg::reg_cfg_s cfg_o;
  logic [12:0] fld;
  int mismatches = 0;
  int num_checks = 0;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic [12:0] v;} row_s;
  // the table only programs limit codes 1000 to 1111
  row_s rows[6] = '{'{8'h02, 8'h00, 8'h00, 13'h0b22}, '{8'h02, 8'h1f, 8'h1f, 13'h1130},
    '{8'h03, 8'h01, 8'h01, 13'h0b54}, '{8'h04, 8'h28, 8'h28, 13'h05dc},
    '{8'h04, 8'hcf, 8'h0f, 13'h1388}, '{8'h04, 8'h1d, 8'h1d, 13'h04e2}};
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  boost_limit_config_regs #(.HIT_CYCLES(10)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
    .rdata_o(rdata_o), .boost_mode_i(boost_i), .avg_limit_active_i(avg_i), .cfg_o(cfg_o));
  boost_limit_host u_host (.clk_i(clk_i), .req_o(req));
  task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00);
    chk("rdata", {5'h00, rdata_o}, {5'h00, e});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_i);
    #1 resetn_i = 1;
    @(posedge clk_i);
    #1 chk("floor_mv", cfg_o.floor_mv, 13'h0c4e);
    chk("ceiling_mv", cfg_o.ceiling_mv, 13'h0e10);
    chk("limit_ma", cfg_o.limit_ma, 13'h0fa0);
    chk("soft_ma", cfg_o.soft_start_ma, 13'h04e2);
    chk("limit_en", {12'h000, cfg_o.limit_enable}, 13'h0001);
    rd(8'h02, 8'h06);
    rd(8'h03, 8'h0f);
    rd(8'h04, 8'h1d);
    foreach (rows[i]) begin
      u_host.xfer(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
      fld = rows[i].a == 8'h02 ? cfg_o.floor_mv : rows[i].a == 8'h03 ? cfg_o.ceiling_mv : cfg_o.soft_start_ma;
      chk("decoded", fld, rows[i].v);
      if (rows[i].a == 8'h04) begin
        chk("limit_en", {12'h000, cfg_o.limit_enable}, {12'h000, ~rows[i].d[5]});
      end
    end
    // reserved low code is refused while the control bits still land
    u_host.xfer(1'b1, 8'h04, 8'h23);
    rd(8'h04, 8'h2d);
    chk("limit_ma", cfg_o.limit_ma, 13'h0fa0);
    chk("soft_ma", cfg_o.soft_start_ma, 13'h0fa0);
    chk("limit_en", {12'h000, cfg_o.limit_enable}, 13'h0000);
    // condition held past the hit time, then dropped before readout
    boost_i = 1;
    avg_i = 1;
    repeat (12) @(posedge clk_i);
    #1 avg_i = 0;
    rd(8'h05, 8'h04);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    resetn_i = 0;
    repeat (2) @(posedge clk_i);
    #1 resetn_i = 1;
    rd(8'h02, 8'h06);
    chk("limit_ma", cfg_o.limit_ma, 13'h0fa0);
    chk("ceiling_mv", cfg_o.ceiling_mv, 13'h0e10);
    chk("limit_en", {12'h000, cfg_o.limit_enable}, 13'h0001);
    conclude();
  end
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule

// ---- rtl/boost_limit_config_regs.sv ----
// register bank holding voltage targets and current limit settings of the boost regulator
`timescale 1ns/1ps
module boost_limit_config_regs #(
  parameter int HIT_CYCLES = boost_limit_pkg::HIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register access from the i2c transport
  input wire boost_limit_pkg::reg_req_s req_i,
  output logic [7:0] rdata_o,
  // regulator side
  input wire logic boost_mode_i,
  input wire logic avg_limit_active_i,
  output boost_limit_pkg::reg_cfg_s cfg_o
);
  // ****************************************
  // storage
  // ****************************************
  logic [4:0] floor_reg;
  logic [4:0] ceiling_reg;
  logic [5:0] limit_reg;
  logic hit_flag_reg;
  logic [31:0] hit_count_reg;
  logic [7:0] rdata_reg;
  wire sel_floor = req_i.addr == boost_limit_pkg::OFS_FLOOR;
  wire sel_ceiling = req_i.addr == boost_limit_pkg::OFS_CEILING;
  wire sel_limit = req_i.addr == boost_limit_pkg::OFS_LIMIT;
  wire sel_status = req_i.addr == boost_limit_pkg::OFS_STATUS;
  // reserved low codes are refused so the limit never decodes to an undefined value
  wire code_ok = req_i.wdata[3:0] >= boost_limit_pkg::LIMIT_CODE_MIN;
  wire [3:0] code_next = code_ok ? req_i.wdata[3:0] : limit_reg[3:0];
  wire [5:0] limit_next = {req_i.wdata[boost_limit_pkg::LIMIT_OFF_POS],
    req_i.wdata[boost_limit_pkg::SOFT_START_POS], code_next};
  wire hit_done = hit_count_reg >= HIT_CYCLES - 1;
  wire hit_event = boost_mode_i && avg_limit_active_i && hit_done;
  wire status_read = req_i.read && sel_status;
  // reserved bits read back as zero
  wire [7:0] floor_word = {3'h0, floor_reg};
  wire [7:0] ceiling_word = {3'h0, ceiling_reg};
  wire [7:0] limit_word = {2'h0, limit_reg};
  // only the boost limit flag exists in the status byte, the rest reads zero
  wire [7:0] status_word = 8'(hit_flag_reg) << boost_limit_pkg::STATUS_FLAG_POS;
  wire [7:0] rdata_next = sel_floor ? floor_word :
    sel_ceiling ? ceiling_word :
    sel_limit ? limit_word :
    sel_status ? status_word : 8'h00;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      floor_reg <= boost_limit_pkg::FLOOR_RESET;
      ceiling_reg <= boost_limit_pkg::CEILING_RESET;
      limit_reg <= {1'b0, 1'b1, boost_limit_pkg::LIMIT_CODE_RESET};
      rdata_reg <= 8'h00;
    end else begin
      if (req_i.write && sel_floor) floor_reg <= req_i.wdata[4:0];
      if (req_i.write && sel_ceiling) ceiling_reg <= req_i.wdata[4:0];
      if (req_i.write && sel_limit) limit_reg <= limit_next;
      if (req_i.read) rdata_reg <= rdata_next;
    end
  end
  // ****************************************
  // limit hit timer and sticky flag
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hit_count_reg <= 32'h0;
      hit_flag_reg <= 1'b0;
    end else begin
      // the counter saturates, so a long hold keeps setting the flag after a read
      if (!(boost_mode_i && avg_limit_active_i)) hit_count_reg <= 32'h0;
      else if (!hit_done) hit_count_reg <= hit_count_reg + 32'h1;
      // set wins over the read clear
      if (hit_event) hit_flag_reg <= 1'b1;
      else if (status_read) hit_flag_reg <= 1'b0;
    end
  end
  assign rdata_o = rdata_reg;
  // ****************************************
  // decoded settings for the regulator
  // ****************************************
  logic [12:0] floor_mv;
  logic [12:0] ceiling_mv;
  logic [12:0] code_ma;
  assign floor_mv = 13'(boost_limit_pkg::VOLT_BASE_MV + 13'(floor_reg) * boost_limit_pkg::VOLT_STEP_MV);
  assign ceiling_mv = 13'(boost_limit_pkg::VOLT_BASE_MV + 13'(ceiling_reg) * boost_limit_pkg::VOLT_STEP_MV);
  assign code_ma = 13'(boost_limit_pkg::CURR_BASE_MA
    + 13'(limit_reg[3:0] - boost_limit_pkg::LIMIT_CODE_MIN) * boost_limit_pkg::CURR_STEP_MA);
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.floor_mv <= floor_mv;
      cfg_o.ceiling_mv <= ceiling_mv;
      cfg_o.limit_enable <= !limit_reg[boost_limit_pkg::LIMIT_OFF_POS];
      cfg_o.limit_ma <= code_ma;
      cfg_o.soft_start_ma <= limit_reg[boost_limit_pkg::SOFT_START_POS] ?
        boost_limit_pkg::SOFT_START_MA : code_ma;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  a_floor_reset_value: assert property (@(posedge clk_i) !resetn_i |=> floor_reg == 5'h06)
    else $error("floor reset wrong");
  a_ceiling_reset_value: assert property (@(posedge clk_i) !resetn_i |=> ceiling_reg == 5'h0f)
    else $error("ceiling reset wrong");
  a_limit_reset_value: assert property (@(posedge clk_i) !resetn_i |=> limit_reg == 6'h1d)
    else $error("limit reset wrong");
  a_floor_decode_scale: assert property (@(posedge clk_i) disable iff (!resetn_i)
    floor_mv == 13'd2850 + 13'(floor_reg) * 13'd50)
    else $error("floor decode wrong");
  a_ceiling_decode_scale: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ceiling_reg == 5'h01 |-> ceiling_mv == 13'd2900)
    else $error("ceiling decode wrong");
  a_limit_off_bit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.write && sel_limit |=> ##1 cfg_o.limit_enable == !$past(req_i.wdata[5], 2))
    else $error("limit disable wrong");
  a_soft_start_cap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    limit_reg[4] |=> cfg_o.soft_start_ma == 13'd1250)
    else $error("soft start cap wrong");
  a_soft_start_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !limit_reg[4] && limit_reg[3:0] == 4'hf |=> cfg_o.soft_start_ma == 13'd5000)
    else $error("soft start code wrong");
  a_hit_flag_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    hit_event |=> hit_flag_reg)
    else $error("hit flag not set");
  a_hit_flag_cause: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(hit_flag_reg) |-> $past(boost_mode_i && avg_limit_active_i))
    else $error("hit flag without cause");
  // ****************************************
  // checks: register writes
  // ****************************************
  a_floor_write_lands: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.write && sel_floor
    |=> floor_reg == $past(req_i.wdata[4:0]))
    else $error("floor write lost");
  a_ceiling_write_lands: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.write && sel_ceiling
    |=> ceiling_reg == $past(req_i.wdata[4:0]))
    else $error("ceiling write lost");
  a_limit_code_take: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.write && sel_limit && req_i.wdata[3:0] >= 4'h8
    |=> limit_reg[3:0] == $past(req_i.wdata[3:0]))
    else $error("limit code write lost");
  a_limit_code_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.write && sel_limit && req_i.wdata[3:0] < 4'h8
    |=> limit_reg[3:0] == $past(limit_reg[3:0]))
    else $error("reserved limit code stored");
  a_limit_bits_take: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.write && sel_limit
    |=> limit_reg[5:4] == $past(req_i.wdata[5:4]))
    else $error("limit control bits lost");
  // ****************************************
  // checks: decoded settings
  // ****************************************
  a_ceiling_decode_full: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1
    |-> ceiling_mv == 13'd2850 + 13'(ceiling_reg) * 13'd50)
    else $error("ceiling scale wrong");
  a_limit_code_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    limit_reg[3:0] == 4'h8
    |-> code_ma == 13'd1500)
    else $error("lowest limit code wrong");
  a_limit_code_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
    limit_reg[3:0] == 4'hf
    |-> code_ma == 13'd5000)
    else $error("highest limit code wrong");
  a_limit_enable_on: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !limit_reg[5]
    |=> cfg_o.limit_enable)
    else $error("limit not enabled");
  a_limit_enable_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
    limit_reg[5]
    |=> !cfg_o.limit_enable)
    else $error("limit not disabled");
  a_soft_start_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !limit_reg[4]
    |=> cfg_o.soft_start_ma == $past(code_ma))
    else $error("soft start ignores limit code");
  a_floor_out_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1
    |=> cfg_o.floor_mv == $past(floor_mv))
    else $error("floor output stale");
  // ****************************************
  // checks: status flag and readback
  // ****************************************
  a_hit_flag_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_read && !hit_event
    |=> !hit_flag_reg)
    else $error("hit flag not cleared");
  a_hit_flag_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !hit_event && !status_read
    |=> hit_flag_reg == $past(hit_flag_reg))
    else $error("hit flag changed alone");
  a_hit_count_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(boost_mode_i && avg_limit_active_i)
    |=> hit_count_reg == 32'h0)
    else $error("hit timer not cleared");
  a_status_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_read
    |=> rdata_o[2] == $past(hit_flag_reg))
    else $error("status readback wrong");
  a_floor_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.read && sel_floor
    |=> rdata_o == {3'h0, $past(floor_reg)})
    else $error("floor readback wrong");
  a_ceiling_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.read && sel_ceiling
    |=> rdata_o == {3'h0, $past(ceiling_reg)})
    else $error("ceiling readback wrong");
  a_limit_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.read && sel_limit
    |=> rdata_o == {2'h0, $past(limit_reg)})
    else $error("limit readback wrong");
endmodule

// ---- rtl/boost_limit_pkg.sv ----
// constants and carrier types for the boost limit configuration registers
package boost_limit_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_FLOOR = 8'h02;
  localparam logic [7:0] OFS_CEILING = 8'h03;
  localparam logic [7:0] OFS_LIMIT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h05;
  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [4:0] FLOOR_RESET = 5'h06;
  localparam logic [4:0] CEILING_RESET = 5'h0f;
  localparam logic [3:0] LIMIT_CODE_RESET = 4'hd;
  localparam logic [3:0] LIMIT_CODE_MIN = 4'h8;
  localparam int LIMIT_OFF_POS = 5;
  localparam int SOFT_START_POS = 4;
  localparam int STATUS_FLAG_POS = 2;
  // voltage code: 2850 mV base, 50 mV step; current code: 1500 mA at code 8, 500 mA step
  localparam logic [12:0] VOLT_BASE_MV = 13'h0b22;
  localparam logic [12:0] VOLT_STEP_MV = 13'h0032;
  localparam logic [12:0] CURR_BASE_MA = 13'h05dc;
  localparam logic [12:0] CURR_STEP_MA = 13'h01f4;
  localparam logic [12:0] SOFT_START_MA = 13'h04e2;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 50000000;
  localparam int HIT_TIME_US = 1500;
  localparam int HIT_CYCLES = CLK_HZ / 1000000 * HIT_TIME_US;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic [12:0] floor_mv;
    logic [12:0] ceiling_mv;
    logic limit_enable;
    logic [12:0] limit_ma;
    logic [12:0] soft_start_ma;
  } reg_cfg_s;
endpackage
